/* serial_peripheral_master.sv */
// Serial peripheral master with APB register slave
//
// The APB interface to the registers was decided locally.
module serial_peripheral_master (
    input wire logic clock,
    input wire logic rst,
    input wire spi_master_pkg::apb_req_t apb_req,
    output spi_master_pkg::apb_rsp_t apb_rsp,
    input wire logic miso,
    output spi_master_pkg::spi_pins_t spi_pins,
    output logic irq
);
    spi_master_pkg::state_t st;
    spi_master_pkg::state_t next_st;

    function automatic logic cfg_bit(input logic [15:0] cfg, input logic [1:0] sel,
                                     input int pos);
        return cfg[spi_master_pkg::DCFG_STRIDE * sel + pos];
    endfunction

    function automatic logic [15:0] reg_index(input logic [spi_master_pkg::ADDR_W-1:0] a);
        return a[spi_master_pkg::ADDR_W-1:2];
    endfunction

    logic access;
    logic wr_fire;
    logic [15:0] idx;
    logic [15:0] half;
    logic tick;
    logic rx_bit;
    logic pol;
    logic pha;
    logic char_done;
    logic sample;
    logic [6:0] last_edge;

    assign apb_rsp = st.rsp;
    assign spi_pins = st.pins;
    assign irq = st.irq;

    always_comb begin
        logic [31:0] rdata;
        logic hit;
        logic start;
        logic lead;
        logic shift_out;
        logic [1:0] set_ist;
        logic [1:0] clr_ist;
        logic [12:0] frames_inc;
        logic [4:0] new_len;
        logic [1:0] new_sel;
        rdata = 32'h00000000;
        hit = 1'b1;
        start = 1'b0;
        lead = 1'b0;
        shift_out = 1'b0;
        set_ist = 2'h0;
        clr_ist = 2'h0;
        frames_inc = 13'(st.frames + 13'h0001);
        new_len = st.lenm1;
        new_sel = st.sel;
        next_st = st;
        char_done = 1'b0;
        sample = 1'b0;
        access = apb_req.psel & apb_req.penable;
        wr_fire = access & st.rsp.pready & apb_req.pwrite;
        idx = reg_index(apb_req.paddr);
        // Fastest legal clock: a half period of two system clocks
        half = (st.clock_divider < spi_master_pkg::MIN_HALF) ? spi_master_pkg::MIN_HALF
                                                              : st.clock_divider;
        tick = (st.cnt == 16'h0000);
        pol = cfg_bit(st.device_config_low, st.sel, spi_master_pkg::DCFG_POL);
        pha = cfg_bit(st.device_config_low, st.sel, spi_master_pkg::DCFG_PHA);
        // Loopback takes the bit we are driving, never the pin
        rx_bit = st.device_config_high[spi_master_pkg::DCFG2_LOOP] ? st.pins.mosi
                                                                  : miso;
        last_edge = {1'b0, st.lenm1, 1'b1};

        case (idx)
            spi_master_pkg::IDX_CLOCK_DIVIDER: rdata = {16'h0000, st.clock_divider};
            spi_master_pkg::IDX_CLOCK_CONTROL: rdata = {16'h0000, st.clock_control};
            spi_master_pkg::IDX_DEVICE_CONFIG_LOW: rdata = {16'h0000, st.device_config_low};
            spi_master_pkg::IDX_DEVICE_CONFIG_HIGH: rdata = {16'h0000, st.device_config_high};
            spi_master_pkg::IDX_COMMAND_LOW: rdata = {16'h0000, st.command_low};
            spi_master_pkg::IDX_COMMAND_HIGH: rdata = {16'h0000, st.command_high};
            spi_master_pkg::IDX_STATUS_LOW: begin
                rdata[spi_master_pkg::STAT1_BUSY] = (st.fsm != spi_master_pkg::S_IDLE);
                rdata[spi_master_pkg::STAT1_WAIT] = (st.fsm == spi_master_pkg::S_WAIT);
            end
            spi_master_pkg::IDX_STATUS_HIGH: rdata = {19'h00000, st.frames};
            spi_master_pkg::IDX_DATA_LOW: rdata = {16'h0000, st.rxd[15:0]};
            spi_master_pkg::IDX_DATA_HIGH: rdata = {16'h0000, st.rxd[31:16]};
            spi_master_pkg::IDX_IRQ_STATUS: rdata = {30'h00000000, st.ist};
            spi_master_pkg::IDX_IRQ_MASK: rdata = {30'h00000000, st.imask};
            default: hit = 1'b0;
        endcase

        // Answer one cycle into the access phase
        next_st.rsp.pready = access & ~st.rsp.pready;
        if (access & ~st.rsp.pready) begin
            next_st.rsp.prdata = apb_req.pwrite ? 32'h00000000 : rdata;
            next_st.rsp.pslverr = ~hit;
        end

        if (wr_fire) begin
            case (idx)
                spi_master_pkg::IDX_CLOCK_DIVIDER: next_st.clock_divider = apb_req.pwdata[15:0];
                spi_master_pkg::IDX_CLOCK_CONTROL: next_st.clock_control = apb_req.pwdata[15:0];
                spi_master_pkg::IDX_DEVICE_CONFIG_LOW:
                    next_st.device_config_low = apb_req.pwdata[15:0];
                spi_master_pkg::IDX_DEVICE_CONFIG_HIGH:
                    next_st.device_config_high = apb_req.pwdata[15:0];
                spi_master_pkg::IDX_COMMAND_LOW: next_st.command_low = apb_req.pwdata[15:0];
                spi_master_pkg::IDX_COMMAND_HIGH: begin
                    next_st.command_high = apb_req.pwdata[15:0];
                    // Starts while shifting or disabled are dropped
                    start = apb_req.pwdata[spi_master_pkg::CMD2_START]
                            & st.clock_control[spi_master_pkg::CCR_ENABLE]
                            & ((st.fsm == spi_master_pkg::S_IDLE)
                               | (st.fsm == spi_master_pkg::S_WAIT));
                    new_len = apb_req.pwdata[spi_master_pkg::CMD2_LEN_LSB +: 5];
                end
                spi_master_pkg::IDX_DATA_LOW: next_st.txd[15:0] = apb_req.pwdata[15:0];
                spi_master_pkg::IDX_DATA_HIGH: next_st.txd[31:16] = apb_req.pwdata[15:0];
                spi_master_pkg::IDX_IRQ_STATUS: clr_ist = apb_req.pwdata[1:0];
                spi_master_pkg::IDX_IRQ_MASK: next_st.imask = apb_req.pwdata[1:0];
                default: ;
            endcase
        end

        case (st.fsm)
            spi_master_pkg::S_IDLE: begin
                new_sel = st.command_high[spi_master_pkg::CMD2_SEL_LSB +: 2];
                next_st.pins.sclk = cfg_bit(st.device_config_low, new_sel,
                                            spi_master_pkg::DCFG_POL);
                if (start) begin
                    new_sel = apb_req.pwdata[spi_master_pkg::CMD2_SEL_LSB +: 2];
                    next_st.fsm = spi_master_pkg::S_SETUP;
                    next_st.sel = new_sel;
                    next_st.frames = 13'h0000;
                    next_st.pins.sclk = cfg_bit(st.device_config_low, new_sel,
                                                spi_master_pkg::DCFG_POL);
                    next_st.dly = 3'(3'h1 + {st.device_config_high[
                                  spi_master_pkg::DCFG2_DELAY_LSB +: 2], 1'b0});
                end
            end
            spi_master_pkg::S_SETUP: begin
                if (tick) begin
                    if (st.dly == 3'h1) begin
                        next_st.fsm = spi_master_pkg::S_SHIFT;
                    end else begin
                        next_st.dly = 3'(st.dly - 3'h1);
                    end
                end
            end
            spi_master_pkg::S_SHIFT: begin
                if (tick) begin
                    // Only this state toggles the serial clock; idle parks it at the polarity level
                    next_st.pins.sclk = ~st.pins.sclk;
                    next_st.edge_n = 7'(st.edge_n + 7'h01);
                    lead = ~st.edge_n[0];
                    // Phase 0 samples on leading edges, phase 1 on trailing
                    sample = lead ? ~pha : pha;
                    shift_out = lead ? (pha & (st.edge_n != 7'h00))
                                     : (~pha & (st.edge_n != last_edge));
                    if (sample) begin
                        next_st.rsh = {st.rsh[30:0], rx_bit};
                    end
                    if (shift_out) begin
                        next_st.sh = {st.sh[30:0], 1'b0};
                    end
                    if (st.edge_n == last_edge) begin
                        char_done = 1'b1;
                        next_st.rxd = next_st.rsh & (32'hFFFFFFFF >> (5'h1F - st.lenm1));
                        next_st.frames = frames_inc;
                        if (frames_inc == 13'({1'b0, st.command_low[
                                spi_master_pkg::CMD1_FLEN_LSB +: 12]} + 13'h0001)) begin
                            next_st.fsm = spi_master_pkg::S_HOLD;
                            set_ist[spi_master_pkg::IRQ_FRAME] = 1'b1;
                        end else begin
                            next_st.fsm = spi_master_pkg::S_WAIT;
                        end
                        if (st.command_low[spi_master_pkg::CMD1_CIE]) begin
                            set_ist[spi_master_pkg::IRQ_CHAR] = 1'b1;
                        end
                    end
                end
            end
            spi_master_pkg::S_WAIT: begin
                if (start) begin
                    next_st.fsm = spi_master_pkg::S_SHIFT;
                end
            end
            spi_master_pkg::S_HOLD: begin
                if (tick) begin
                    next_st.fsm = spi_master_pkg::S_IDLE;
                end
            end
            default: next_st.fsm = spi_master_pkg::S_IDLE;
        endcase

        if (start) begin
            // Left align so the top bit leaves first
            next_st.lenm1 = new_len;
            next_st.sh = st.txd << (5'h1F - new_len);
            next_st.rsh = 32'h00000000;
            next_st.edge_n = 7'h00;
            next_st.cnt = 16'(half - 16'h0001);
        end else if (st.fsm != spi_master_pkg::S_IDLE) begin
            next_st.cnt = tick ? 16'(half - 16'h0001) : 16'(st.cnt - 16'h0001);
        end

        // Set wins over a clear in the same cycle
        next_st.ist = (st.ist & ~clr_ist) | set_ist;
        next_st.irq = |(next_st.ist & next_st.imask);

        for (int i = 0; i < 4; i++) begin
            // Drive the configured active level only on the addressed slave
            next_st.pins.slave_select_n[i] =
                ((next_st.fsm != spi_master_pkg::S_IDLE) && (next_st.sel == 2'(i)))
                ? cfg_bit(next_st.device_config_low, 2'(i), spi_master_pkg::DCFG_CSP)
                : ~cfg_bit(next_st.device_config_low, 2'(i), spi_master_pkg::DCFG_CSP);
        end
        next_st.pins.mosi = (next_st.fsm == spi_master_pkg::S_IDLE) ? 1'b0
                                                                    : next_st.sh[31];
    end

    // No DMA request port exists; software moves every word over APB
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.pins.slave_select_n <= spi_master_pkg::SS_RESET;
            st.clock_divider <= spi_master_pkg::REG_RESET;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic [3:0] sel_active;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            sel_active[i] = (st.pins.slave_select_n[i]
                == cfg_bit(st.device_config_low, 2'(i), spi_master_pkg::DCFG_CSP));
        end
    end

    sequence seq_char_end;
        char_done;
    endsequence

    sequence seq_enter_setup;
        (st.fsm == spi_master_pkg::S_IDLE) ##1 (st.fsm == spi_master_pkg::S_SETUP);
    endsequence

    a_clock_only_shift: assert property (
        $changed(st.pins.sclk) && ($past(st.fsm) != spi_master_pkg::S_IDLE)
        |-> ($past(st.fsm) == spi_master_pkg::S_SHIFT))
        else $error("serial clock moved outside shifting");
    a_half_period_min: assert property (
        $changed(st.pins.sclk) && (st.fsm != spi_master_pkg::S_IDLE) |=> $stable(st.pins.sclk))
        else $error("serial clock half period below two cycles");
    a_one_select: assert property (
        $onehot0(sel_active) && ((st.fsm != spi_master_pkg::S_IDLE) == (sel_active != 4'h0)))
        else $error("select outputs do not match transfer state");
    a_setup_delay: assert property (
        seq_enter_setup |-> (st.fsm != spi_master_pkg::S_SHIFT) [*2])
        else $error("data started too soon after select");
    a_frame_end: assert property (
        seq_char_end ##0 (next_st.fsm == spi_master_pkg::S_HOLD)
        |=> (st.fsm == spi_master_pkg::S_HOLD) && st.ist[spi_master_pkg::IRQ_FRAME])
        else $error("frame end not flagged");
    a_char_irq_gate: assert property (
        $rose(st.ist[spi_master_pkg::IRQ_CHAR])
        |-> $past(char_done && st.command_low[spi_master_pkg::CMD1_CIE]))
        else $error("character flag set without enabled completion");
    a_loopback_path: assert property (
        sample && st.device_config_high[spi_master_pkg::DCFG2_LOOP]
        |=> st.rsh[0] == $past(st.pins.mosi))
        else $error("loopback bit not taken from transmit");
    a_irq_level: assert property (
        |(st.ist & st.imask) |-> ##[0:1] irq)
        else $error("unmasked flag did not raise interrupt");
    a_idle_polarity: assert property (
        (st.fsm == spi_master_pkg::S_IDLE) [*2] ##0 $stable(st.device_config_low)
        ##0 $stable(st.command_high)
        |-> st.pins.sclk == cfg_bit(st.device_config_low,
                st.command_high[spi_master_pkg::CMD2_SEL_LSB +: 2], spi_master_pkg::DCFG_POL))
        else $error("idle clock not at polarity level");
endmodule // serial_peripheral_master

/* spi_master_pkg.sv */
// Constants, types and state layout for the serial peripheral master
// Behaviour
// - Port is bus master only; it always drives serial clock and selects.
// - Each character shifts out and in together; length 1 to 32 bits.
// - Four separate slave select outputs; one slave addressed per transfer.
// - No DMA requests; all data moves through processor register accesses.
// - Frame length 1 to 4096 characters, completed characters counted against it.
// - Optional interrupt on each completed character; none when disabled.
// - Select to first clock delay of 1, 2, 3 or 4 serial clocks.
// - Each select output may be active low or active high.
// - Mode 0 samples on rising edge, changes data after falling edge.
// - Mode 1 samples on falling edge, changes data after rising edge.
// - Mode 2 samples on falling edge, changes data after rising edge.
// - Serial clock from programmable divider; period never below four system clocks.
// - Loopback mode returns transmitted bits to receive path internally.
// - Clock polarity and phase chosen separately for each slave select.
package spi_master_pkg;
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_CLOCK_DIVIDER = 16'h3000;
    localparam logic [15:0] IDX_CLOCK_CONTROL = 16'h3001;
    localparam logic [15:0] IDX_DEVICE_CONFIG_LOW = 16'h3002;
    localparam logic [15:0] IDX_DEVICE_CONFIG_HIGH = 16'h3003;
    localparam logic [15:0] IDX_COMMAND_LOW = 16'h3004;
    localparam logic [15:0] IDX_COMMAND_HIGH = 16'h3005;
    localparam logic [15:0] IDX_STATUS_LOW = 16'h3006;
    localparam logic [15:0] IDX_STATUS_HIGH = 16'h3007;
    localparam logic [15:0] IDX_DATA_LOW = 16'h3008;
    localparam logic [15:0] IDX_DATA_HIGH = 16'h3009;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'h300A;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h300B;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam int CCR_ENABLE = 0;
    localparam int DCFG_STRIDE = 4;
    localparam int DCFG_POL = 0;
    localparam int DCFG_PHA = 1;
    localparam int DCFG_CSP = 2;
    localparam int DCFG2_DELAY_LSB = 0;
    localparam int DCFG2_LOOP = 2;
    localparam int CMD1_FLEN_LSB = 0;
    localparam int CMD1_CIE = 14;
    localparam int CMD2_LEN_LSB = 0;
    localparam int CMD2_SEL_LSB = 12;
    localparam int CMD2_START = 15;
    localparam int STAT1_BUSY = 0;
    localparam int STAT1_WAIT = 1;
    localparam int IRQ_CHAR = 0;
    localparam int IRQ_FRAME = 1;
    localparam logic [15:0] MIN_HALF = 16'h0002;
    localparam logic [3:0] SS_RESET = 4'hF;
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_SHIFT, S_WAIT, S_HOLD} fsm_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } apb_rsp_t;
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic [3:0] slave_select_n;
    } spi_pins_t;
    typedef struct packed {
        fsm_t fsm;
        logic [15:0] clock_divider;
        logic [15:0] clock_control;
        logic [15:0] device_config_low;
        logic [15:0] device_config_high;
        logic [15:0] command_low;
        logic [15:0] command_high;
        logic [31:0] txd;
        logic [31:0] rxd;
        logic [31:0] sh;
        logic [31:0] rsh;
        logic [15:0] cnt;
        logic [6:0] edge_n;
        logic [2:0] dly;
        logic [12:0] frames;
        logic [1:0] sel;
        logic [4:0] lenm1;
        logic [1:0] ist;
        logic [1:0] imask;
        logic irq;
        apb_rsp_t rsp;
        spi_pins_t pins;
    } state_t;
endpackage

/* spi_slave_model.sv */
// Behavioural slave device on the far side of the serial port
module spi_slave_model (
    input wire logic clock,
    input wire logic rst,
    input wire spi_master_pkg::spi_pins_t pins,
    input wire logic [1:0] sel,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic csh,
    input wire logic [31:0] tx_word,
    input wire logic [5:0] len,
    output logic miso,
    output logic [31:0] rx_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic act, act_d, sclk_d, first, last, lead, trail;
    logic [31:0] sh;
    assign act = pins.slave_select_n[sel] == csh;
    assign lead = act && pins.sclk != sclk_d && pins.sclk != cpol;
    assign trail = act && pins.sclk != sclk_d && pins.sclk == cpol;
    // Deselected line shows the inverse, so a stale bit cannot pass
    assign miso = act ? sh[31] : ~last;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            {act_d, sclk_d, first, last, sh, rx_word} <= '0;
        end else begin
            act_d <= act;
            sclk_d <= pins.sclk;
            if (act) last <= sh[31];
            if (act && !act_d) begin
                sh <= tx_word << (6'd32 - len);
                rx_word <= '0;
                first <= 1'b1;
            end else begin
                if (cpha ? trail : lead) rx_word <= {rx_word[30:0], pins.mosi};
                if (cpha ? lead && !first : trail) sh <= sh << 1;
                if (lead) first <= 1'b0;
            end
        end
    end
endmodule // spi_slave_model

/* tb_top.sv */
// Self-checking bench for the serial peripheral master
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] d; logic chk; logic err;} exp_t;
    logic clock, rst, miso, irq, s_pol, s_pha, s_csh;
    spi_master_pkg::apb_req_t req;
    spi_master_pkg::apb_rsp_t rsp;
    spi_master_pkg::spi_pins_t pins;
    logic [1:0] s_sel;
    logic [31:0] s_tx, rx_word;
    logic [5:0] s_len;
    exp_t exp_q[$];
    exp_t got;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    serial_peripheral_master serial_peripheral_master_inst (.clock(clock), .rst(rst),
        .apb_req(req), .apb_rsp(rsp), .miso(miso), .spi_pins(pins), .irq(irq));
    spi_slave_model spi_slave_model_inst (.clock(clock), .rst(rst), .pins(pins), .sel(s_sel),
        .cpol(s_pol), .cpha(s_pha), .csh(s_csh), .tx_word(s_tx), .len(s_len), .miso(miso),
        .rx_word(rx_word));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic final_report();
        if (err_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Generous ceiling; a full run needs about a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end
    always @(posedge clock) begin
        if (rsp.pready === 1'b1) begin
            if (exp_q.size() == 0) check("pready", 32'h1, 32'h0);
            else begin
                got = exp_q.pop_front();
                if (got.chk) check("prdata", rsp.prdata, got.d);
                check("pslverr", 32'(rsp.pslverr), 32'(got.err));
            end
        end
    end
    // Idle cycle first, so psel never gets two assignments in one step
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       input logic [31:0] ed, input logic eerr);
        int n = 0;
        @(posedge clock);
        exp_q.push_back('{ed, !wr, eerr});
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= {idx, 2'b00};
        req.pwdata <= wd;
        @(posedge clock);
        req.penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) check("apb_wait", 32'h0, 32'h1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] ed);
        apb(1'b0, idx, 32'h0, ed, 1'b0);
    endtask
    task automatic irq_after(input logic want);
        repeat (2) @(posedge clock);
        check("irq", 32'(irq), 32'(want));
    endtask
    function automatic logic [31:0] lmask(input int l);
        return (l == 32) ? 32'hFFFF_FFFF : ((32'h1 << l) - 32'h1);
    endfunction
    task automatic wait_serial(input int h, input int setup, input logic [3:0] idle,
                               input int l, input logic pol);
        int n = 0;
        int k = 0;
        int t = 0;
        int lt = 0;
        logic p;
        p = pins.sclk;
        while (n < 4000 && k < 2 * h + 2) begin
            @(posedge clock);
            n++;
            if (irq === 1'b1 || k > 0) k++;
            if (pins.sclk !== p) begin
                if (t > 0) check("half_period", 32'(n - lt), 32'(h));
                else if (setup > 0) check("setup", 32'(n), 32'((setup + 1) * h + 1));
                if (t == 0) check("ss_on", 32'(pins.slave_select_n ^ idle), 32'(4'h1 << s_sel));
                t++;
                lt = n;
                p = pins.sclk;
            end
        end
        check("toggles", 32'(t), 32'(2 * l));
        check("ss_idle", 32'(pins.slave_select_n), 32'(idle));
        check("sclk_idle", 32'(pins.sclk), 32'(pol));
    endtask
    initial begin
        logic [31:0] d, d1, stx, ex, c;
        int l, h, dv;
        d = $urandom(32'h6440);
        rst = 1'b1;
        req = '0;
        {s_sel, s_pol, s_pha, s_csh, s_tx, s_len} = '0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check("ss_reset", 32'(pins.slave_select_n), 32'(spi_master_pkg::SS_RESET));
        for (int i = 0; i < 12; i++) rd(16'h3000 + 16'(i), 32'(spi_master_pkg::REG_RESET));
        // Keep enable and active-high selects clear so random starts stay refused
        for (int i = 0; i < 6; i++) begin
            d = ($urandom | 32'h8000) & 32'hFFFF_BBBA;
            wr(16'h3000 + 16'(i), d);
            rd(16'h3000 + 16'(i), {16'h0, d[15:0]});
        end
        check("start_off", 32'(pins.slave_select_n), 32'hF);
        wr(16'h3006, 32'hFFFF);
        rd(16'h3006, 32'h0);
        apb(1'b0, 16'h300C, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 16'h300C, 32'h5A5A, 32'h0, 1'b1);
        for (int m = 0; m < 4; m++) begin
            l = (m == 0) ? 32 : (m == 1) ? 1 : 1 + $urandom % 32;
            dv = (m == 1) ? 5 : m;
            h = (dv < 2) ? 2 : dv;
            d = $urandom;
            stx = $urandom;
            {s_sel, s_pol, s_pha, s_csh, s_tx, s_len} <= {2'(m), m[1], m[0], m[0], stx, 6'(l)};
            wr(16'h3000, 32'(dv));
            wr(16'h3001, 32'h1);
            wr(16'h3002, 32'({m[0], m[0], m[1]}) << (4 * m));
            wr(16'h3003, 32'({m == 3, m[1:0]}));
            wr(16'h300B, 32'h3);
            wr(16'h3004, 32'h4000);
            wr(16'h3008, {16'h0, d[15:0]});
            wr(16'h3009, {16'h0, d[31:16]});
            c = {17'h0, 1'b0, 2'(m), 7'h0, 5'(l - 1)};
            wr(16'h3005, c);
            wr(16'h3005, c | 32'h8000);
            wait_serial(h, 1 + 2 * m, 4'hF ^ (4'(m[0]) << m), l, m[1]);
            check("slave_rx", rx_word, d & lmask(l));
            ex = ((m == 3) ? d : stx) & lmask(l);
            rd(16'h3008, {16'h0, ex[15:0]});
            rd(16'h3009, {16'h0, ex[31:16]});
            rd(16'h300A, 32'h3);
            check("irq_set", 32'(irq), 32'h1);
            wr(16'h300A, 32'h3);
            irq_after(1'b0);
        end
        {s_sel, s_pol, s_pha, s_csh, s_len} <= {2'h0, 3'h0, 6'd8};
        wr(16'h3000, 32'h0);
        wr(16'h3002, 32'h0);
        wr(16'h3003, 32'h0);
        wr(16'h3004, 32'h1);
        d = $urandom;
        d1 = $urandom;
        wr(16'h3008, {24'h0, d[7:0]});
        wr(16'h3005, 32'h8007);
        repeat (60) @(posedge clock);
        check("irq_off", 32'(irq), 32'h0);
        check("ss_hold", 32'(pins.slave_select_n), 32'hE);
        rd(16'h3007, 32'h1);
        rd(16'h3006, 32'h3);
        rd(16'h300A, 32'h0);
        wr(16'h3008, {24'h0, d1[7:0]});
        wr(16'h3005, 32'h8007);
        wait_serial(2, 0, 4'hF, 8, 1'b0);
        check("frame_rx", rx_word & 32'hFFFF, {16'h0, d[7:0], d1[7:0]});
        rd(16'h300A, 32'h2);
        wr(16'h300B, 32'h0);
        irq_after(1'b0);
        wr(16'h300B, 32'h2);
        irq_after(1'b1);
        wr(16'h300A, 32'h2);
        irq_after(1'b0);
        final_report();
    end
endmodule // tb_top
